// [design/adc_ctl_pkg.sv]
// constants, register map and types of the converter power and debug control
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 32;
  localparam int FLAG_W = 6;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CONTROL_A     = 5'h00;
  localparam logic [4:0] OFF_CONTROL_B     = 5'h01;
  localparam logic [4:0] OFF_CONTROL_C     = 5'h02;
  localparam logic [4:0] OFF_CONTROL_D     = 5'h03;
  localparam logic [4:0] OFF_INT_ENABLE    = 5'h04;
  localparam logic [4:0] OFF_INT_FLAGS     = 5'h05;
  localparam logic [4:0] OFF_STATUS        = 5'h06;
  localparam logic [4:0] OFF_DEBUG_CONTROL = 5'h07;
  localparam logic [4:0] OFF_CONTROL_E     = 5'h08;
  localparam logic [4:0] OFF_CONTROL_F     = 5'h09;
  localparam logic [4:0] OFF_COMMAND       = 5'h0A;
  localparam logic [4:0] OFF_AMPLIFIER     = 5'h0B;
  localparam logic [4:0] OFF_MUX_POS       = 5'h0C;
  localparam logic [4:0] OFF_MUX_NEG       = 5'h0D;
  localparam logic [4:0] OFF_RESULT        = 5'h10;
  localparam logic [4:0] OFF_SAMPLE        = 5'h14;
  localparam logic [4:0] OFF_SCRATCH_0     = 5'h18;
  localparam logic [4:0] OFF_SCRATCH_1     = 5'h19;
  localparam logic [4:0] OFF_SCRATCH_2     = 5'h1A;
  localparam logic [4:0] OFF_WIN_LOW       = 5'h1C;
  localparam logic [4:0] OFF_WIN_HIGH      = 5'h1E;

  // ----------------------------------------------------------------
  // field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int STANDBY_RUN_POS    = 7;
  localparam int KEEP_ANALOG_POS    = 5;
  localparam int ENABLE_POS         = 0;
  localparam int RUN_HALTED_POS     = 0;
  localparam int BUSY_POS           = 0;
  localparam int FLAG_RESULT_POS    = 0;
  localparam int FLAG_TRIG_OVR_POS  = 5;
  localparam int START_LSB          = 0;
  localparam int START_W            = 3;
  localparam logic [7:0] MASK_CONTROL_A = 8'hA1;
  localparam logic [7:0] MASK_INT       = 8'h3F;
  localparam logic [7:0] MASK_DEBUG     = 8'h01;
  localparam logic [7:0] MASK_FULL      = 8'hFF;
  localparam logic [7:0] MASK_NONE      = 8'h00;
  localparam logic [7:0] RESET_REG      = 8'h00;
  localparam logic [5:0] RESET_FLAGS    = 6'h00;

  // ----------------------------------------------------------------
  // start field settings
  // ----------------------------------------------------------------
  localparam logic [2:0] START_IMMEDIATE     = 3'h1;
  localparam logic [2:0] START_EVENT_TRIGGER = 3'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLEEP_ACTIVE  = 2'b00,
    SLEEP_IDLE    = 2'b01,
    SLEEP_STANDBY = 2'b10,
    SLEEP_DEEPEST = 2'b11
  } sleep_mode_e;

  typedef enum logic [1:0] {
    ST_READY      = 2'b00,
    ST_CONVERTING = 2'b01,
    ST_STOPPED    = 2'b11
  } conv_state_e;

endpackage

// [design/adc_event_if.sv]
// carrier between the control block and its event input detector
`timescale 1ns/1ns
interface adc_event_if;
  logic pin;
  logic pulse;
  modport detector (input pin, output pulse);
  modport control  (output pin, input pulse);
endinterface

// [design/adc_event_sync.sv]
// two-stage synchroniser and rising edge detector for the start event pin
`timescale 1ns/1ns
module adc_event_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  // event path
  adc_event_if.detector evt
);

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic pulse_q;

  // ----------------------------------------------------------------
  // synchroniser and edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      last_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      meta_q  <= evt.pin;
      sync_q  <= meta_q;
      last_q  <= sync_q;
      pulse_q <= sync_q & ~last_q;
    end
  end

  assign evt.pulse = pulse_q;

endmodule

// [design/adc_power_debug_control.sv]
// converter control across sleep states, debug halt and analog power gating
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module adc_power_debug_control
  import adc_ctl_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // system state
  input  wire logic [1:0]        sleep_mode_i,
  input  wire logic              debug_halt_i,
  // event pin
  input  wire logic              event_start_i,
  // sequencer side
  input  wire logic              conv_done_i,
  input  wire logic [31:0]       result_i,
  input  wire logic [15:0]       sample_i,
  output logic                   conv_start_o,
  output logic                   conv_abort_o,
  output logic                   conv_busy_o,
  // power and clock
  output logic                   analog_power_o,
  output logic                   clk_request_o,
  output logic                   converter_enable_o,
  output logic                   sleeping_o,
  // interrupt
  output logic                   irq_o
);

  logic [DATA_W-1:0] regs_q [0:NUM_REGS-1];
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  conv_state_e       state_q;
  conv_state_e       state_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] read_value;
  logic              start_q;
  logic              abort_q;
  logic              busy_q;
  logic              power_q;
  logic              clk_req_q;
  logic              enable_q;
  logic              sleeping_q;
  logic              irq_q;
  logic              start_now;
  logic              abort_now;
  logic              power_d;
  logic              enable_bit;
  logic              standby_run;
  logic              keep_analog;
  logic              run_halted;
  logic              event_cfg;
  logic              sw_start;
  logic              evt_pulse;
  logic              in_idle;
  logic              in_standby;
  logic              in_deepest;
  logic              halt_stop;
  logic              awake;
  logic              stop_req;
  logic              trigger;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] write_mask(input logic [4:0] a);
    case (a)
      OFF_CONTROL_A:     write_mask = MASK_CONTROL_A;
      OFF_INT_ENABLE:    write_mask = MASK_INT;
      OFF_DEBUG_CONTROL: write_mask = MASK_DEBUG;
      OFF_CONTROL_B, OFF_CONTROL_C, OFF_CONTROL_D, OFF_CONTROL_E, OFF_CONTROL_F,
      OFF_COMMAND, OFF_AMPLIFIER, OFF_MUX_POS, OFF_MUX_NEG, OFF_SCRATCH_0,
      OFF_SCRATCH_1, OFF_SCRATCH_2, OFF_WIN_LOW, OFF_WIN_LOW + 5'h01,
      OFF_WIN_HIGH, OFF_WIN_HIGH + 5'h01: write_mask = MASK_FULL;
      default:           write_mask = MASK_NONE;
    endcase
  endfunction

  // reserved bits are never stored, so they read as zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= RESET_REG;
      end
    end else if (reg_write_i) begin
      regs_q[reg_addr_i] <= (regs_q[reg_addr_i] & ~write_mask(reg_addr_i))
                          | (reg_wdata_i & write_mask(reg_addr_i));
    end
  end

  assign enable_bit  = regs_q[OFF_CONTROL_A][ENABLE_POS];
  assign standby_run = regs_q[OFF_CONTROL_A][STANDBY_RUN_POS];
  assign keep_analog = regs_q[OFF_CONTROL_A][KEEP_ANALOG_POS];
  assign run_halted  = regs_q[OFF_DEBUG_CONTROL][RUN_HALTED_POS];
  assign event_cfg   = regs_q[OFF_COMMAND][START_LSB +: START_W] == START_EVENT_TRIGGER;
  assign sw_start    = reg_write_i && (reg_addr_i == OFF_COMMAND)
                    && (reg_wdata_i[START_LSB +: START_W] == START_IMMEDIATE);

  // ----------------------------------------------------------------
  // event input
  // ----------------------------------------------------------------
  adc_event_if evt_if ();

  assign evt_if.pin = event_start_i;
  assign evt_pulse  = evt_if.pulse;

  adc_event_sync u_event_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .evt       (evt_if.detector)
  );

  // ----------------------------------------------------------------
  // sleep and halt decisions
  // ----------------------------------------------------------------
  assign in_idle    = sleep_mode_i == SLEEP_IDLE;
  assign in_standby = sleep_mode_i == SLEEP_STANDBY;
  assign in_deepest = sleep_mode_i == SLEEP_DEEPEST;
  assign halt_stop  = debug_halt_i && !run_halted;
  assign awake      = (sleep_mode_i == SLEEP_ACTIVE) && !halt_stop;

  // a set stop request is honoured between conversions; deepest sleep also aborts a running one
  assign stop_req = in_deepest || halt_stop
                 || (in_idle && !event_cfg)
                 || (in_standby && !(standby_run && event_cfg));

  // software starts need an awake cpu or a debug halt with the run bit set, event starts do not
  assign trigger = (event_cfg && evt_pulse) || (sw_start && awake);

  // ----------------------------------------------------------------
  // conversion state
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    start_now = 1'b0;
    abort_now = 1'b0;
    case (state_q)
      ST_READY: begin
        if (!enable_bit) begin
          state_d = ST_READY;
        end else if (stop_req) begin
          state_d = ST_STOPPED;
        end else if (trigger) begin
          state_d   = ST_CONVERTING;
          start_now = 1'b1;
        end
      end
      ST_CONVERTING: begin
        if (!enable_bit || in_deepest) begin
          abort_now = 1'b1;
          state_d   = enable_bit ? ST_STOPPED : ST_READY;
        end else if (conv_done_i) begin
          state_d = stop_req ? ST_STOPPED : ST_READY;
        end
      end
      ST_STOPPED: begin
        if (!enable_bit || !stop_req) begin
          state_d = ST_READY;
        end
      end
      default: begin
        state_d = ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer, power and clock outputs
  // ----------------------------------------------------------------
  // keep-analog covers the analog modules only, never the clock
  always_comb begin
    power_d = enable_bit && ((state_d == ST_CONVERTING)
           || (keep_analog && !in_deepest
               && ((state_d != ST_STOPPED) || (in_standby && standby_run))));
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      start_q    <= 1'b0;
      abort_q    <= 1'b0;
      busy_q     <= 1'b0;
      power_q    <= 1'b0;
      clk_req_q  <= 1'b0;
      enable_q   <= 1'b0;
      sleeping_q <= 1'b0;
    end else begin
      start_q    <= start_now;
      abort_q    <= abort_now;
      busy_q     <= state_d == ST_CONVERTING;
      power_q    <= power_d;
      clk_req_q  <= in_standby && (state_d == ST_CONVERTING);
      enable_q   <= enable_bit;
      sleeping_q <= state_d == ST_STOPPED;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  always_comb begin
    flag_set = RESET_FLAGS;
    flag_set[FLAG_TRIG_OVR_POS] = trigger && enable_bit && (state_q == ST_CONVERTING);
    flag_set[FLAG_RESULT_POS]   = conv_done_i && !abort_now && (state_q == ST_CONVERTING);
    flag_clr = (reg_write_i && (reg_addr_i == OFF_INT_FLAGS)) ?
               reg_wdata_i[FLAG_W-1:0] : RESET_FLAGS;
    // a new event outranks a clear in the same cycle
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      flags_q <= RESET_FLAGS;
      irq_q   <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q   <= |(flags_d & regs_q[OFF_INT_ENABLE][FLAG_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      OFF_INT_FLAGS: read_value = {2'b00, flags_q};
      OFF_STATUS:    read_value = {7'h00, state_q == ST_CONVERTING};
      OFF_RESULT:            read_value = result_i[7:0];
      OFF_RESULT + 5'h01:    read_value = result_i[15:8];
      OFF_RESULT + 5'h02:    read_value = result_i[23:16];
      OFF_RESULT + 5'h03:    read_value = result_i[31:24];
      OFF_SAMPLE:            read_value = sample_i[7:0];
      OFF_SAMPLE + 5'h01:    read_value = sample_i[15:8];
      default:       read_value = regs_q[reg_addr_i] & write_mask(reg_addr_i);
    endcase
  end

  // data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_q <= RESET_REG;
    end else begin
      rdata_q <= reg_read_i ? read_value : RESET_REG;
    end
  end

  assign reg_rdata_o        = rdata_q;
  assign conv_start_o       = start_q;
  assign conv_abort_o       = abort_q;
  assign conv_busy_o        = busy_q;
  assign analog_power_o     = power_q;
  assign clk_request_o      = clk_req_q;
  assign converter_enable_o = enable_q;
  assign sleeping_o         = sleeping_q;
  assign irq_o              = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_finish_before_sleep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_CONVERTING) && enable_bit && !in_deepest && !conv_done_i
    |=> (state_q == ST_CONVERTING) && !conv_abort_o)
    else $error("conversion left before completion");

  a_idle_event_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_READY) && enable_bit && in_idle && event_cfg && evt_pulse && !halt_stop
    |=> conv_start_o && conv_busy_o)
    else $error("event start refused in idle sleep");

  a_standby_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_READY) && enable_bit && in_standby && !standby_run
    |=> sleeping_o && !conv_start_o)
    else $error("converter kept running in standby");

  a_standby_power: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    enable_bit && keep_analog && standby_run && in_standby |=> analog_power_o)
    else $error("analog power dropped in standby");

  a_deepest_abort: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_CONVERTING) && enable_bit && in_deepest
    |=> conv_abort_o && sleeping_o && !conv_busy_o)
    else $error("no immediate abort on deepest sleep");

  a_halt_running: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_READY) && enable_bit && debug_halt_i && run_halted
    && (sleep_mode_i == SLEEP_ACTIVE) && sw_start |=> conv_start_o)
    else $error("start refused while halted with run bit set");

  a_halt_finish: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_CONVERTING) && enable_bit && halt_stop && conv_done_i && !in_deepest
    |=> sleeping_o ##1 sleeping_o || !debug_halt_i)
    else $error("converter did not halt after conversion");

  a_clock_request: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_q == ST_READY) && enable_bit && in_standby && standby_run && event_cfg
    && evt_pulse && !halt_stop |=> clk_request_o && conv_start_o)
    else $error("main clock not requested in standby");

  a_power_at_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(analog_power_o) && !$past(keep_analog) |-> conv_start_o)
    else $error("analog powered without a start");

  a_keep_powered: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    enable_bit && keep_analog && awake |=> analog_power_o)
    else $error("analog power dropped with keep-analog set");

  a_no_clock_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !conv_busy_o |-> !clk_request_o)
    else $error("clock requested between conversions");

  a_disable_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !enable_bit |=> !conv_busy_o && !converter_enable_o && !conv_start_o)
    else $error("disabled converter still active");

  a_control_a_mask: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_write_i && (reg_addr_i == OFF_CONTROL_A)
    |=> regs_q[OFF_CONTROL_A] == ($past(reg_wdata_i) & MASK_CONTROL_A))
    else $error("control A write not stored as expected");

  a_event_setting: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    conv_start_o && !$past(sw_start) |-> $past(event_cfg))
    else $error("event start without event setting");

  a_busy_status: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_read_i && (reg_addr_i == OFF_STATUS)
    |=> reg_rdata_o[BUSY_POS] == $past(state_q == ST_CONVERTING))
    else $error("busy flag disagrees with conversion state");

  a_flag_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    flag_set[FLAG_RESULT_POS] |=> flags_q[FLAG_RESULT_POS])
    else $error("result flag lost against a clear");

endmodule

// [verification/tb_top.sv]
// self-checking bench for the converter power and debug control
`timescale 1ns/1ns
module tb_top;
  import adc_ctl_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic              clk_sys_i;
  logic              rstn_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic              reg_write_i;
  logic              reg_read_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [1:0]        sleep_mode_i;
  logic              debug_halt_i;
  logic              event_start_i;
  logic              conv_done_i;
  logic [31:0]       result_i;
  logic [15:0]       sample_i;
  logic              conv_start_o;
  logic              conv_abort_o;
  logic              conv_busy_o;
  logic              analog_power_o;
  logic              clk_request_o;
  logic              converter_enable_o;
  logic              sleeping_o;
  logic              irq_o;
  int                err_count;
  int                checks_done;

  adc_power_debug_control dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .sleep_mode_i(sleep_mode_i),
    .debug_halt_i(debug_halt_i), .event_start_i(event_start_i),
    .conv_done_i(conv_done_i), .result_i(result_i), .sample_i(sample_i),
    .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
    .conv_busy_o(conv_busy_o), .analog_power_o(analog_power_o),
    .clk_request_o(clk_request_o), .converter_enable_o(converter_enable_o),
    .sleeping_o(sleeping_o), .irq_o(irq_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  task automatic wait_busy(input logic exp);
    int i;
    for (i = 0; i < 16; i++) begin
      tick(1);
      if (conv_busy_o === exp) break;
    end
    if (i == 16) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic start_imm;
    wr(OFF_COMMAND, {5'h00, START_IMMEDIATE});
    #1;
    chk(conv_start_o, 1'b1);
    wait_busy(1'b1);
    chk(conv_start_o, 1'b0);
  endtask
  task automatic done;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b1;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    wait_busy(1'b0);
  endtask
  task automatic pulse_event;
    @(posedge clk_sys_i);
    event_start_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    event_start_i <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(OFF_CONTROL_A, 8'h00);
    rd(5'h0E, 8'h00);
    wr(OFF_CONTROL_A, 8'hFF);
    rd(OFF_CONTROL_A, 8'hA1);
    rd(OFF_RESULT + 5'h02, 8'hC3);
    rd(OFF_SAMPLE + 5'h01, 8'h5A);
    tick(2);
    chk(converter_enable_o, 1'b1);
    wr(OFF_CONTROL_A, 8'h00);
    tick(2);
    chk(converter_enable_o, 1'b0);
    wr(OFF_COMMAND, {5'h00, START_IMMEDIATE});
    tick(4);
    chk(conv_busy_o, 1'b0);
  endtask
  task automatic t_busy_irq;
    wr(OFF_CONTROL_A, 8'h01);
    wr(OFF_INT_ENABLE, 8'h20);
    tick(2);
    chk(analog_power_o, 1'b0);
    start_imm();
    rd(OFF_STATUS, 8'h01);
    chk(analog_power_o, 1'b1);
    // retrigger while busy must not restart, only flag overrun
    wr(OFF_COMMAND, {5'h00, START_IMMEDIATE});
    done();
    rd(OFF_STATUS, 8'h00);
    rd(OFF_INT_FLAGS, 8'h21);
    chk(irq_o, 1'b1);
    wr(OFF_INT_ENABLE, 8'h00);
    tick(2);
    chk(irq_o, 1'b0);
    wr(OFF_INT_ENABLE, 8'h3F);
    wr(OFF_INT_FLAGS, 8'h21);
    tick(2);
    chk(irq_o, 1'b0);
    rd(OFF_INT_FLAGS, 8'h00);
  endtask
  task automatic t_idle;
    pulse_event();
    tick(8);
    chk(conv_busy_o, 1'b0);
    start_imm();
    sleep_mode_i <= SLEEP_IDLE;
    tick(4);
    chk({conv_busy_o, sleeping_o}, 2'b10);
    done();
    chk(sleeping_o, 1'b1);
    wr(OFF_COMMAND, {5'h00, START_EVENT_TRIGGER});
    pulse_event();
    wait_busy(1'b1);
    done();
    sleep_mode_i <= SLEEP_ACTIVE;
  endtask
  task automatic t_standby;
    wr(OFF_CONTROL_A, 8'hA1);
    sleep_mode_i <= SLEEP_STANDBY;
    tick(3);
    chk({analog_power_o, clk_request_o}, 2'b10);
    pulse_event();
    wait_busy(1'b1);
    chk(clk_request_o, 1'b1);
    done();
    tick(1);
    chk(clk_request_o, 1'b0);
    wr(OFF_CONTROL_A, 8'h21);
    tick(2);
    chk(sleeping_o, 1'b1);
    pulse_event();
    tick(8);
    chk(conv_busy_o, 1'b0);
    sleep_mode_i <= SLEEP_ACTIVE;
    wr(OFF_CONTROL_A, 8'h01);
    wr(OFF_COMMAND, {5'h00, START_IMMEDIATE});
  endtask
  task automatic t_deepest;
    wait_busy(1'b1);
    sleep_mode_i <= SLEEP_DEEPEST;
    tick(1);
    chk({conv_abort_o, conv_busy_o, sleeping_o}, 3'b101);
    tick(1);
    chk(analog_power_o, 1'b0);
    sleep_mode_i <= SLEEP_ACTIVE;
    tick(2);
    // software side waits for completion before the deepest sleep
    start_imm();
    done();
    sleep_mode_i <= SLEEP_DEEPEST;
    tick(2);
    chk({conv_abort_o, sleeping_o}, 2'b01);
    sleep_mode_i <= SLEEP_ACTIVE;
    tick(2);
  endtask
  task automatic t_debug;
    start_imm();
    debug_halt_i <= 1'b1;
    tick(4);
    chk({conv_busy_o, sleeping_o}, 2'b10);
    done();
    chk(sleeping_o, 1'b1);
    debug_halt_i <= 1'b0;
    wr(OFF_DEBUG_CONTROL, 8'h01);
    debug_halt_i <= 1'b1;
    start_imm();
    chk(sleeping_o, 1'b0);
    done();
    debug_halt_i <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn_i, reg_write_i, reg_read_i, debug_halt_i, event_start_i} = 5'h00;
    {reg_addr_i, reg_wdata_i, conv_done_i} = 14'h0000;
    sleep_mode_i = SLEEP_ACTIVE;
    result_i = 32'hA5C3_1E77;
    sample_i = 16'h5A96;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_regs();
    t_busy_irq();
    t_idle();
    t_standby();
    t_deepest();
    t_debug();
    complete_run();
  end
endmodule
